// >>> xlcs_chk.sv
// Checks on the link between the lane end and the controller end.
`timescale 1ns/1ps
`default_nettype none
module xlcs_chk (
    // Clock and reset
    input wire logic CLK,
    input wire logic SYS_RST,
    // Link signals
    input wire logic lane1_cfg_access_en,
    input wire logic lane1_cfg_access_done,
    input wire logic lane1_cfg_port_busy,
    input wire logic lane1_rx_attach_reset,
    input wire logic lane1_rx_attach_reset_complete
);
    wire en = lane1_cfg_access_en;
    wire dn = lane1_cfg_access_done;
    wire bz = lane1_cfg_port_busy;
    wire rr = lane1_rx_attach_reset;
    wire rc = lane1_rx_attach_reset_complete;
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    property p_lat; en |-> ##4 dn; endproperty
    property p_src; dn |-> $past(en, 4); endproperty
    property p_one; dn |=> !dn; endproperty
    property p_gap; en |=> !en [*3]; endproperty
    property p_hold; bz |-> !en; endproperty
    property p_bzrc; bz |-> !rc; endproperty
    property p_free; $fell(bz) |-> rc; endproperty
    property p_rx; rr |-> ##[1:2] !rc ##[1:10] rc; endproperty
    a_lat: assert property (p_lat) else $error("late done");
    a_src: assert property (p_src) else $error("stray done");
    a_one: assert property (p_one) else $error("long done");
    a_gap: assert property (p_gap) else $error("early enable");
    a_hold: assert property (p_hold) else $error("busy access");
    a_bzrc: assert property (p_bzrc) else $error("busy flag");
    a_free: assert property (p_free) else $error("busy drop");
    a_rx: assert property (p_rx) else $error("rx reset");
    c_acc: cover property (en ##4 dn);
    c_free: cover property ($fell(bz));
    c_rx: cover property (rr);
endmodule
`default_nettype wire

// >>> xlcs_ctrl_end.sv
// Controller end: APB registers that drive the lane's control port.
`timescale 1ns/1ps
`default_nettype none
module xlcs_ctrl_end (
    // Clock and reset
    input wire logic CLK,
    input wire logic SYS_RST,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [xlcs_pkg::APB_ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Link to the lane
    xlcs_if.ctrl LINK
);
    logic setup;
    logic wr;
    logic pending;
    logic inflight;
    logic [xlcs_pkg::CFG_DATA_W-1:0] rdata_q;
    logic [xlcs_pkg::ERR_W-1:0] eye_errs;
    logic [31:0] rd_mux;
    logic mapped;

    assign setup = PSEL && !PENABLE && !PREADY;
    assign wr = PSEL && PENABLE && PREADY && PWRITE;

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        mapped = 1'b1;
        unique case (PADDR)
            xlcs_pkg::REG_CTRL: rd_mux[7:0] = {LINK.lane1_hf_boost_override,
                LINK.lane1_hf_boost_hold, LINK.lane1_eq_path_select,
                LINK.lane1_loop_select, LINK.lane1_rx_invert,
                LINK.lane1_tx_invert};
            xlcs_pkg::REG_ACTION: rd_mux = 32'h0000_0000;
            xlcs_pkg::REG_CFG_CMD: rd_mux = 32'h0000_0000;
            xlcs_pkg::REG_STATUS: rd_mux[5:0] = {LINK.lane1_pll_locked,
                LINK.lane1_rx_reset_complete,
                LINK.lane1_rx_attach_reset_complete,
                LINK.lane1_tx_reset_complete, LINK.lane1_cfg_port_busy,
                pending || inflight};
            xlcs_pkg::REG_RDATA: rd_mux[15:0] = rdata_q;
            xlcs_pkg::REG_EYE_ERRS: rd_mux[15:0] = eye_errs;
            default: mapped = 1'b0;
        endcase
    end

    // Every transfer has exactly one access cycle.
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            PREADY <= 1'b0;
            PRDATA <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end
        else
        begin
            PREADY <= setup;
            PRDATA <= (setup && !PWRITE) ? rd_mux : 32'h0000_0000;
            PSLVERR <= setup && !mapped;
        end
    end

    // Static lane controls.
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            LINK.lane1_tx_invert <= 1'b0;
            LINK.lane1_rx_invert <= 1'b0;
            LINK.lane1_loop_select <= '0;
            LINK.lane1_eq_path_select <= 1'b0;
            LINK.lane1_hf_boost_hold <= 1'b0;
            LINK.lane1_hf_boost_override <= 1'b0;
        end
        else if (wr && PADDR == xlcs_pkg::REG_CTRL)
        begin
            LINK.lane1_tx_invert <= PWDATA[0];
            LINK.lane1_rx_invert <= PWDATA[1];
            LINK.lane1_loop_select <= PWDATA[4:2];
            LINK.lane1_eq_path_select <= PWDATA[5];
            LINK.lane1_hf_boost_hold <= PWDATA[6];
            LINK.lane1_hf_boost_override <= PWDATA[7];
        end
    end

    // One-cycle action pulses; each reset is high for one cycle, then low.
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            LINK.lane1_tx_attach_reset <= 1'b0;
            LINK.lane1_tx_coding_reset <= 1'b0;
            LINK.lane1_rx_attach_reset <= 1'b0;
            LINK.lane1_rx_coding_reset <= 1'b0;
            LINK.lane1_eye_trigger <= 1'b0;
            LINK.lane1_eye_reset <= 1'b0;
            LINK.lane1_linear_eq_reset <= 1'b0;
        end
        else
        begin
            LINK.lane1_tx_attach_reset <= wr &&
                PADDR == xlcs_pkg::REG_ACTION && PWDATA[0];
            LINK.lane1_tx_coding_reset <= wr &&
                PADDR == xlcs_pkg::REG_ACTION && PWDATA[1];
            LINK.lane1_rx_attach_reset <= wr &&
                PADDR == xlcs_pkg::REG_ACTION && PWDATA[2];
            LINK.lane1_rx_coding_reset <= wr &&
                PADDR == xlcs_pkg::REG_ACTION && PWDATA[3];
            LINK.lane1_eye_trigger <= wr &&
                PADDR == xlcs_pkg::REG_ACTION && PWDATA[4];
            LINK.lane1_eye_reset <= wr &&
                PADDR == xlcs_pkg::REG_ACTION && PWDATA[5];
            LINK.lane1_linear_eq_reset <= wr &&
                PADDR == xlcs_pkg::REG_ACTION && PWDATA[6];
        end
    end

    // Configuration command: queued, issued once the port is free, and
    // retired by the lane's done strobe. A command while one is pending or in flight is dropped.
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            pending <= 1'b0;
            inflight <= 1'b0;
            rdata_q <= '0;
            LINK.lane1_cfg_access_en <= 1'b0;
            LINK.lane1_cfg_write_sel <= 1'b0;
            LINK.lane1_cfg_addr <= '0;
            LINK.lane1_cfg_wdata <= '0;
        end
        else
        begin
            LINK.lane1_cfg_access_en <= 1'b0;
            if (wr && PADDR == xlcs_pkg::REG_CFG_CMD && !pending && !inflight)
            begin
                pending <= 1'b1;
                LINK.lane1_cfg_addr <= PWDATA[xlcs_pkg::CFG_ADDR_W-1:0];
                LINK.lane1_cfg_write_sel <= PWDATA[xlcs_pkg::CMD_WRITE_BIT];
                LINK.lane1_cfg_wdata <= PWDATA[xlcs_pkg::CMD_WDATA_LSB +:
                                               xlcs_pkg::CFG_DATA_W];
            end
            else if (pending && !LINK.lane1_cfg_port_busy)
            begin
                pending <= 1'b0;
                inflight <= 1'b1;
                LINK.lane1_cfg_access_en <= 1'b1;
            end
            if (inflight && LINK.lane1_cfg_access_done)
            begin
                inflight <= 1'b0;
                if (!LINK.lane1_cfg_write_sel)
                    rdata_q <= LINK.lane1_cfg_rdata;
            end
        end
    end

    // Saturating eye error count; an error in the clearing cycle counts.
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
            eye_errs <= '0;
        else if (LINK.lane1_eye_error_pulse)
        begin
            if (wr && PADDR == xlcs_pkg::REG_EYE_ERRS)
                eye_errs <= xlcs_pkg::ERR_ONE;
            else if (eye_errs != xlcs_pkg::ERR_MAX)
                eye_errs <= eye_errs + xlcs_pkg::ERR_ONE;
        end
        else if (wr && PADDR == xlcs_pkg::REG_EYE_ERRS)
            eye_errs <= '0;
    end
endmodule
`default_nettype wire

// >>> xlcs_if.sv
// Signals between the lane end and the controller end.
`timescale 1ns/1ps
`default_nettype none
interface xlcs_if;
    logic [xlcs_pkg::CFG_ADDR_W-1:0] lane1_cfg_addr;
    logic lane1_cfg_access_en;
    logic lane1_cfg_write_sel;
    logic [xlcs_pkg::CFG_DATA_W-1:0] lane1_cfg_wdata;
    logic [xlcs_pkg::CFG_DATA_W-1:0] lane1_cfg_rdata;
    logic lane1_cfg_access_done;
    logic lane1_cfg_port_busy;
    logic lane1_tx_attach_reset;
    logic lane1_tx_coding_reset;
    logic lane1_tx_reset_complete;
    logic lane1_rx_attach_reset;
    logic lane1_rx_coding_reset;
    logic lane1_rx_attach_reset_complete;
    logic lane1_rx_reset_complete;
    logic lane1_pll_locked;
    logic lane1_eye_trigger;
    logic lane1_eye_reset;
    logic lane1_eye_error_pulse;
    logic [xlcs_pkg::LOOP_W-1:0] lane1_loop_select;
    logic lane1_rx_invert;
    logic lane1_tx_invert;
    logic lane1_eq_path_select;
    logic lane1_linear_eq_reset;
    logic lane1_hf_boost_hold;
    logic lane1_hf_boost_override;

    modport lane (
        input lane1_cfg_addr, lane1_cfg_access_en, lane1_cfg_write_sel,
        input lane1_cfg_wdata, lane1_tx_attach_reset, lane1_tx_coding_reset,
        input lane1_rx_attach_reset, lane1_rx_coding_reset,
        input lane1_eye_trigger, lane1_eye_reset, lane1_loop_select,
        input lane1_rx_invert, lane1_tx_invert, lane1_eq_path_select,
        input lane1_linear_eq_reset, lane1_hf_boost_hold,
        input lane1_hf_boost_override,
        output lane1_cfg_rdata, lane1_cfg_access_done, lane1_cfg_port_busy,
        output lane1_tx_reset_complete, lane1_rx_attach_reset_complete,
        output lane1_rx_reset_complete, lane1_pll_locked,
        output lane1_eye_error_pulse
    );
    modport ctrl (
        output lane1_cfg_addr, lane1_cfg_access_en, lane1_cfg_write_sel,
        output lane1_cfg_wdata, lane1_tx_attach_reset, lane1_tx_coding_reset,
        output lane1_rx_attach_reset, lane1_rx_coding_reset,
        output lane1_eye_trigger, lane1_eye_reset, lane1_loop_select,
        output lane1_rx_invert, lane1_tx_invert, lane1_eq_path_select,
        output lane1_linear_eq_reset, lane1_hf_boost_hold,
        output lane1_hf_boost_override,
        input lane1_cfg_rdata, lane1_cfg_access_done, lane1_cfg_port_busy,
        input lane1_tx_reset_complete, lane1_rx_attach_reset_complete,
        input lane1_rx_reset_complete, lane1_pll_locked,
        input lane1_eye_error_pulse
    );
endinterface
`default_nettype wire

// >>> xlcs_lane_end.sv
// Lane end: configuration space, reset sequencing, eye scan and datapath.
// Operation
// - Access enable high starts one access.
// - Write select low reads, high writes.
// - Nine-bit address, sixteen-bit data both ways.
// - Access done marks write finished or data valid.
// - Controller holds off accesses while port busy.
// - Transmit resets run; completion flag follows.
// - Receive resets run; completion flag follows.
// - Receive attach reset completion flag, active high.
// - Eye error pulses one cycle when armed/counting.
// - Eye reset is pulsed high then low.
// - Linear equalizer reset pulsed high then low.
// - Path select low feedback, high linear.
// - Receive invert flips incoming serial data.
// - Transmit invert flips outgoing serial data. Not in far attach loopback: there TX_SERIAL repeats rx_sync uninverted.
// - Three-bit loop select picks loopback mode.
// - Lock flag high when PLL within tolerance.
// - Eye trigger input causes trigger event.
// - Boost hold freezes; override selects word.
//
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module xlcs_lane_end (
    // Clock and reset
    input wire logic CLK,
    input wire logic SYS_RST,
    // Link to the controller
    xlcs_if.lane LINK,
    // Serial line
    input wire logic RX_SERIAL,
    output logic TX_SERIAL,
    // Parallel side and equalizer status
    input wire logic TX_BIT,
    output logic RX_BIT,
    output logic EQ_LINEAR,
    output logic [xlcs_pkg::BOOST_W-1:0] HF_BOOST
);
    localparam int NPROC = 3;

    xlcs_pkg::xlcs_cfg_state_t cfg_state;
    logic [xlcs_pkg::CFG_LAT_W-1:0] cfg_cnt;
    logic [xlcs_pkg::CFG_ADDR_W-1:0] cfg_addr_q;
    logic [xlcs_pkg::CFG_DATA_W-1:0] cfg_wdata_q;
    logic cfg_we_q;
    logic cfg_commit;
    logic [xlcs_pkg::CFG_IDX_W-1:0] cfg_idx;
    logic [xlcs_pkg::CFG_DATA_W-1:0] cfg_word [xlcs_pkg::CFG_DEPTH];
    logic [NPROC-1:0] rst_req;
    logic [NPROC-1:0] proc_done;
    logic [xlcs_pkg::CNT_W-1:0] proc_cnt [NPROC];
    logic [xlcs_pkg::CNT_W-1:0] pll_cnt;
    logic rx_sync;
    logic tx_line;
    logic rx_line;
    logic near_loop;
    logic eye_rst_q;
    logic eye_mismatch;
    xlcs_pkg::xlcs_eye_t eye_state;
    logic eq_rst_q;
    logic [xlcs_pkg::CNT_W-1:0] eq_cnt;

    xlcs_sync u_rx_sync (
        .clk(CLK),
        .rst(SYS_RST),
        .din(RX_SERIAL),
        .dout(rx_sync)
    );

    // Configuration access sequencer. Upper address bits alias onto the
    // implemented words; an enable during a running access is ignored.
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            cfg_state <= xlcs_pkg::CFG_IDLE;
            cfg_cnt <= '0;
            cfg_addr_q <= '0;
            cfg_wdata_q <= '0;
            cfg_we_q <= 1'b0;
        end
        else
        begin
            unique case (cfg_state)
                xlcs_pkg::CFG_IDLE:
                begin
                    if (LINK.lane1_cfg_access_en)
                    begin
                        cfg_state <= xlcs_pkg::CFG_WAIT;
                        cfg_cnt <= xlcs_pkg::CFG_LATENCY - 2'h1;
                        cfg_addr_q <= LINK.lane1_cfg_addr;
                        cfg_wdata_q <= LINK.lane1_cfg_wdata;
                        cfg_we_q <= LINK.lane1_cfg_write_sel;
                    end
                end
                xlcs_pkg::CFG_WAIT:
                begin
                    if (cfg_cnt == '0)
                        cfg_state <= xlcs_pkg::CFG_IDLE;
                    else
                        cfg_cnt <= cfg_cnt - 2'h1;
                end
            endcase
        end
    end

    assign cfg_commit = (cfg_state == xlcs_pkg::CFG_WAIT) && (cfg_cnt == '0);
    assign cfg_idx = cfg_addr_q[xlcs_pkg::CFG_IDX_W-1:0];

    for (genvar i = 0; i < xlcs_pkg::CFG_DEPTH; i++)
    begin : g_cfg
        always_ff @(posedge CLK)
        begin
            if (SYS_RST)
                cfg_word[i] <= xlcs_pkg::CFG_RESET_VAL;
            else if (cfg_commit && cfg_we_q && cfg_idx == i)
                cfg_word[i] <= cfg_wdata_q;
        end
    end

    // Completion strobe with read data; the word is held until the next read.
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            LINK.lane1_cfg_access_done <= 1'b0;
            LINK.lane1_cfg_rdata <= '0;
        end
        else
        begin
            LINK.lane1_cfg_access_done <= cfg_commit;
            if (cfg_commit && !cfg_we_q)
                LINK.lane1_cfg_rdata <= cfg_word[cfg_idx];
        end
    end

    // Reset processes: transmit, receive attach, receive coding.
    assign rst_req[0] = LINK.lane1_tx_attach_reset ||
                        LINK.lane1_tx_coding_reset;
    assign rst_req[1] = LINK.lane1_rx_attach_reset;
    assign rst_req[2] = LINK.lane1_rx_coding_reset;

    for (genvar p = 0; p < NPROC; p++)
    begin : g_proc
        always_ff @(posedge CLK)
        begin
            if (SYS_RST || rst_req[p])
            begin
                proc_cnt[p] <= xlcs_pkg::RESET_CYCLES;
                proc_done[p] <= 1'b0;
            end
            else if (proc_cnt[p] != xlcs_pkg::CNT_ZERO)
            begin
                proc_cnt[p] <= proc_cnt[p] - xlcs_pkg::CNT_ONE;
                proc_done[p] <= (proc_cnt[p] == xlcs_pkg::CNT_ONE);
            end
        end
    end

    // The receive attach layer calibrates through the configuration port, so
    // the port is reported busy while that reset runs.
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            LINK.lane1_tx_reset_complete <= 1'b0;
            LINK.lane1_rx_attach_reset_complete <= 1'b0;
            LINK.lane1_rx_reset_complete <= 1'b0;
            LINK.lane1_cfg_port_busy <= 1'b1;
        end
        else
        begin
            LINK.lane1_tx_reset_complete <= proc_done[0];
            LINK.lane1_rx_attach_reset_complete <= proc_done[1];
            LINK.lane1_rx_reset_complete <= proc_done[1] && proc_done[2];
            LINK.lane1_cfg_port_busy <= !proc_done[1];
        end
    end

    // Lock follows a settle time after reset and after a transmit attach reset.
    always_ff @(posedge CLK)
    begin
        if (SYS_RST || LINK.lane1_tx_attach_reset)
        begin
            pll_cnt <= xlcs_pkg::CNT_ZERO;
            LINK.lane1_pll_locked <= 1'b0;
        end
        else if (pll_cnt != xlcs_pkg::PLL_LOCK_CYCLES)
            pll_cnt <= pll_cnt + xlcs_pkg::CNT_ONE;
        else
            LINK.lane1_pll_locked <= 1'b1;
    end

    // Serial datapath with polarity and loopback.
    assign tx_line = TX_BIT ^ LINK.lane1_tx_invert;
    assign near_loop = (LINK.lane1_loop_select == xlcs_pkg::LOOP_NEAR_CODING)
        || (LINK.lane1_loop_select == xlcs_pkg::LOOP_NEAR_ATTACH);
    assign rx_line = (near_loop ? tx_line : rx_sync) ^
                     LINK.lane1_rx_invert;

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            TX_SERIAL <= 1'b0;
            RX_BIT <= 1'b0;
            EQ_LINEAR <= 1'b0;
        end
        else
        begin
            if (LINK.lane1_loop_select == xlcs_pkg::LOOP_FAR_ATTACH)
                TX_SERIAL <= rx_sync;
            else
                TX_SERIAL <= tx_line;
            RX_BIT <= rx_line;
            EQ_LINEAR <= LINK.lane1_eq_path_select;
        end
    end

    // Eye scan: reset holds idle and arms on release; triggers toggle
    // between armed and counting.
    assign eye_mismatch = (rx_line ^ TX_BIT) &&
        !cfg_word[xlcs_pkg::CFG_EYE_MASK_IDX][0];

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            eye_rst_q <= 1'b0;
            eye_state <= xlcs_pkg::EYE_IDLE;
            LINK.lane1_eye_error_pulse <= 1'b0;
        end
        else
        begin
            eye_rst_q <= LINK.lane1_eye_reset;
            if (LINK.lane1_eye_reset)
                eye_state <= xlcs_pkg::EYE_IDLE;
            else if (eye_rst_q)
                eye_state <= xlcs_pkg::EYE_ARMED;
            else if (LINK.lane1_eye_trigger)
            begin
                unique case (eye_state)
                    xlcs_pkg::EYE_ARMED: eye_state <= xlcs_pkg::EYE_COUNT;
                    xlcs_pkg::EYE_COUNT: eye_state <= xlcs_pkg::EYE_ARMED;
                    default: eye_state <= xlcs_pkg::EYE_IDLE;
                endcase
            end
            LINK.lane1_eye_error_pulse <= eye_mismatch &&
                (eye_state != xlcs_pkg::EYE_IDLE);
        end
    end

    // Linear equalizer: reset runs after release; on the linear path boost adapts
    // on errors unless held, or follows the configuration word when overridden.
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            eq_rst_q <= 1'b0;
            eq_cnt <= xlcs_pkg::CNT_ZERO;
            HF_BOOST <= xlcs_pkg::BOOST_RESET;
        end
        else
        begin
            eq_rst_q <= LINK.lane1_linear_eq_reset;
            if (LINK.lane1_linear_eq_reset)
                HF_BOOST <= xlcs_pkg::BOOST_RESET;
            else if (eq_rst_q)
            begin
                eq_cnt <= xlcs_pkg::EQ_RESET_CYCLES;
                HF_BOOST <= xlcs_pkg::BOOST_RESET;
            end
            else if (eq_cnt != xlcs_pkg::CNT_ZERO)
                eq_cnt <= eq_cnt - xlcs_pkg::CNT_ONE;
            else if (LINK.lane1_hf_boost_override)
                HF_BOOST <= cfg_word[xlcs_pkg::CFG_BOOST_IDX]
                            [xlcs_pkg::BOOST_W-1:0];
            else if (!LINK.lane1_hf_boost_hold && LINK.lane1_eq_path_select
                     && eye_mismatch && HF_BOOST != xlcs_pkg::BOOST_MAX)
                HF_BOOST <= HF_BOOST + 5'h01;
        end
    end
endmodule
`default_nettype wire

// >>> xlcs_pkg.sv
// Shared constants and types for the lane 1 control and status block.
`default_nettype none
package xlcs_pkg;
    // Configuration port shape.
    localparam int CFG_ADDR_W = 9;
    localparam int CFG_DATA_W = 16;
    localparam int CFG_IDX_W = 4;
    localparam int CFG_DEPTH = 16;
    localparam logic [CFG_DATA_W-1:0] CFG_RESET_VAL = 16'h0000;
    localparam logic [CFG_IDX_W-1:0] CFG_EYE_MASK_IDX = 4'h1;
    localparam logic [CFG_IDX_W-1:0] CFG_BOOST_IDX = 4'h2;
    localparam int CFG_LAT_W = 2;
    localparam logic [CFG_LAT_W-1:0] CFG_LATENCY = 2'h3;
    // Clock and process times.
    localparam int CLK_PERIOD_NS = 100;
    localparam int RESET_TIME_NS = 500;
    localparam int PLL_LOCK_NS = 1000;
    localparam int EQ_RESET_NS = 300;
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] RESET_CYCLES =
        CNT_W'((RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] PLL_LOCK_CYCLES =
        CNT_W'((PLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] EQ_RESET_CYCLES =
        CNT_W'((EQ_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
    // Loopback and equalizer.
    localparam int LOOP_W = 3;
    localparam logic [LOOP_W-1:0] LOOP_NEAR_CODING = 3'h1;
    localparam logic [LOOP_W-1:0] LOOP_NEAR_ATTACH = 3'h2;
    localparam logic [LOOP_W-1:0] LOOP_FAR_ATTACH = 3'h4;
    localparam int BOOST_W = 5;
    localparam logic [BOOST_W-1:0] BOOST_RESET = 5'h00;
    localparam logic [BOOST_W-1:0] BOOST_MAX = 5'h1f;
    // Controller register map, byte addresses on APB.
    localparam int APB_ADDR_W = 8;
    localparam logic [APB_ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [APB_ADDR_W-1:0] REG_ACTION = 8'h04;
    localparam logic [APB_ADDR_W-1:0] REG_CFG_CMD = 8'h08;
    localparam logic [APB_ADDR_W-1:0] REG_STATUS = 8'h0c;
    localparam logic [APB_ADDR_W-1:0] REG_RDATA = 8'h10;
    localparam logic [APB_ADDR_W-1:0] REG_EYE_ERRS = 8'h14;
    localparam int CMD_WRITE_BIT = 9;
    localparam int CMD_WDATA_LSB = 16;
    localparam int ERR_W = 16;
    localparam logic [ERR_W-1:0] ERR_MAX = 16'hffff;
    localparam logic [ERR_W-1:0] ERR_ONE = 16'h0001;
    // States.
    typedef enum logic {CFG_IDLE, CFG_WAIT} xlcs_cfg_state_t;
    typedef enum logic [1:0] {EYE_IDLE, EYE_ARMED, EYE_COUNT} xlcs_eye_t;
endpackage
`default_nettype wire

// >>> xlcs_sync.sv
// Two-flop synchroniser for a level from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module xlcs_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Level in and out
    input wire logic din,
    output logic dout
);
    logic meta;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta <= 1'b0;
            dout <= 1'b0;
        end
        else
        begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule
`default_nettype wire

// >>> xlcs_test.sv
// Self-checking bench for the lane 1 control and status block.
`timescale 1ns/1ps
`default_nettype none
module xlcs_test;
    logic CLK = 1'b0, SYS_RST = 1'b1, PSEL = 1'b0;
    logic PENABLE = 1'b0, PWRITE = 1'b0, PREADY, PSLVERR;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0, PRDATA, v;
    logic [16:0] r = 17'h12f2b;
    logic [32:0] q[$];
    int err_count = 0, n_tests = 0;
    logic [5:0] pq[$];
    logic look = 1'b0, eq_lin;
    logic [4:0] boost;
    xlcs_if b ();
    xlcs_lane_end xlcs_lane_end_inst (.CLK, .SYS_RST, .LINK(b.lane),
        .RX_SERIAL(r[0]), .TX_SERIAL(), .TX_BIT(r[3]), .RX_BIT(),
        .EQ_LINEAR(eq_lin), .HF_BOOST(boost));
    xlcs_ctrl_end xlcs_ctrl_end_inst (.CLK, .SYS_RST, .PSEL, .PENABLE,
        .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .LINK(b.ctrl));
    xlcs_chk xlcs_chk_inst (.CLK, .SYS_RST,
        .lane1_cfg_access_en(b.lane1_cfg_access_en),
        .lane1_cfg_access_done(b.lane1_cfg_access_done),
        .lane1_cfg_port_busy(b.lane1_cfg_port_busy),
        .lane1_rx_attach_reset(b.lane1_rx_attach_reset),
        .lane1_rx_attach_reset_complete(b.lane1_rx_attach_reset_complete));
    function automatic logic [16:0] nx(logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction
    task automatic stop_test();
        if (err_count == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(logic [32:0] x);
        logic [32:0] e;
        e = q.pop_front();
        n_tests++;
        if (x !== e)
        begin
            err_count++;
            $display("MISMATCH apb read exp %h got %h", e, x);
        end
    endtask
    // One APB transfer; an idle edge follows so strobes never toggle twice.
    task automatic xfer(logic w, logic [7:0] a, logic [31:0] x);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= x;
        @(posedge CLK) PENABLE <= 1'b1;
        do @(posedge CLK); while (PREADY !== 1'b1);
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge CLK);
    endtask
    task automatic rd(logic [7:0] a, logic [32:0] e);
        q.push_back(e);
        xfer(1'b0, a, 32'h0);
    endtask
    task automatic pchk(logic [5:0] x);
        logic [5:0] e;
        e = pq.pop_front();
        n_tests++;
        if (x !== e)
        begin
            err_count++;
            $display("MISMATCH lane pins exp %h got %h", e, x);
        end
    endtask
    task automatic pin(logic [5:0] e);
        pq.push_back(e);
        look <= 1'b1;
        @(posedge CLK) look <= 1'b0;
    endtask
    always #50 CLK = ~CLK;
    always @(posedge CLK)
        r <= nx(r);
    always @(posedge CLK)
        if (PSEL && PENABLE && PREADY === 1'b1 && !PWRITE)
            chk({PSLVERR, PRDATA});
    always @(posedge CLK)
        if (look)
            pchk({eq_lin, boost});
    initial
    begin
        repeat (2000) @(posedge CLK);
        err_count++;
        stop_test();
    end
    initial
    begin
        repeat (4) @(posedge CLK);
        SYS_RST <= 1'b0;
        repeat (20) @(posedge CLK);
        rd(xlcs_pkg::REG_STATUS, 33'h3c);
        for (int i = 0; i < 8; i++)
        begin
            v = {24'h0, r[7:5], i[2:0], r[1:0]};
            xfer(1'b1, xlcs_pkg::REG_CTRL, v);
            rd(xlcs_pkg::REG_CTRL, {1'b0, v});
        end
        for (int i = 0; i < 4; i++)
        begin
            v = {r[15:0], 6'h00, 1'b1, r[8:0]};
            xfer(1'b1, xlcs_pkg::REG_CFG_CMD, v);
            repeat (6) @(posedge CLK);
            xfer(1'b1, xlcs_pkg::REG_CFG_CMD, {23'h0, v[8:0] ^ 9'h1f0});
            repeat (6) @(posedge CLK);
            rd(xlcs_pkg::REG_RDATA, {17'h0, v[31:16]});
        end
        rd(8'h18, {1'b1, 32'h0});
        xfer(1'b1, xlcs_pkg::REG_ACTION, 32'h1);
        @(posedge CLK);
        rd(xlcs_pkg::REG_STATUS, 33'h18);
        repeat (14) @(posedge CLK);
        xfer(1'b1, xlcs_pkg::REG_ACTION, 32'h4);
        @(posedge CLK);
        rd(xlcs_pkg::REG_STATUS, 33'h26);
        for (int i = 0; i < 7; i++)
        begin
            xfer(1'b1, xlcs_pkg::REG_ACTION, 32'h1 << i);
            repeat (14) @(posedge CLK);
        end
        // Near loopback with one inversion makes every bit an eye error.
        xfer(1'b1, xlcs_pkg::REG_CFG_CMD, 32'h0000_0201);
        repeat (6) @(posedge CLK);
        xfer(1'b1, xlcs_pkg::REG_CTRL, 32'h5);
        xfer(1'b1, xlcs_pkg::REG_ACTION, 32'h20);
        repeat (3) @(posedge CLK);
        xfer(1'b1, xlcs_pkg::REG_EYE_ERRS, 32'h0);
        rd(xlcs_pkg::REG_EYE_ERRS, 33'h2);
        xfer(1'b1, xlcs_pkg::REG_CTRL, 32'h7);
        xfer(1'b1, xlcs_pkg::REG_EYE_ERRS, 32'h0);
        rd(xlcs_pkg::REG_EYE_ERRS, 33'h0);
        v = {11'h0, r[4:0], 16'h0202};
        xfer(1'b1, xlcs_pkg::REG_CFG_CMD, v);
        repeat (6) @(posedge CLK);
        xfer(1'b1, xlcs_pkg::REG_CTRL, 32'ha0);
        pin({1'b1, v[20:16]});
        rd(xlcs_pkg::REG_STATUS, 33'h3c);
        stop_test();
    end
endmodule
`default_nettype wire
